//--- smsp_port.sv
// serial peripheral port, master or slave, with processor registers
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module smsp_port (
    input  wire logic       clk_in,
    input  wire logic       resetn_in,
    input  wire logic [1:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    input  wire logic       gie_in,
    input  wire logic       irq_ack_in,
    output logic            irq_out,
    input  wire logic       sck_dir_in,
    input  wire logic       mosi_dir_in,
    input  wire logic       miso_dir_in,
    input  wire logic       ss_dir_in,
    input  wire logic       ss_value_in,
    input  wire logic       sck_in,
    output logic            sck_out,
    output logic            sck_oe_out,
    input  wire logic       mosi_in,
    output logic            mosi_out,
    output logic            mosi_oe_out,
    input  wire logic       miso_in,
    output logic            miso_out,
    output logic            miso_oe_out,
    input  wire logic       ss_in,
    output logic            ss_out,
    output logic            ss_oe_out
);
    import smsp_pkg::*;

    // whole state of the port in one record
    typedef struct packed {
        logic [7:0] ctrl;     // control register
        logic       dbl;      // double speed bit
        logic       tcf;      // transfer complete flag
        logic       write_collision_flag;     // write collision flag
        logic       arm_tcf;  // status seen with a flag set
        logic       arm_write_collision_flag; // status seen with collision set
        logic [7:0] shift;    // shift register, also the tx byte
        logic [7:0] rxbuf;    // receive buffer
        logic       tx_bit;   // bit currently presented on the line
        logic       m_busy;   // master transfer running
        logic [3:0] edge_cnt; // master sck edge index
        logic [6:0] div_cnt;  // master half period counter
        logic       sck_lvl;  // master sck level
        logic [3:0] bitcnt;   // slave samples in current byte
        logic       ss_s1;    // select sync stage one
        logic       ss_s2;    // select sync stage two
        logic       sck_s1;   // sck sync stage one
        logic       sck_s2;   // sck sync stage two
        logic       sck_s3;   // previous synced sck, for edges
        logic [7:0] rdata;    // read answer
        logic       irq;      // interrupt request
        logic       sck_o;    // pin outputs
        logic       sck_oe;
        logic       mosi_o;
        logic       mosi_oe;
        logic       miso_o;
        logic       miso_oe;
        logic       ss_o;
        logic       ss_oe;
    } smsp_state_type;

    smsp_state_type s;      // registered state
    smsp_state_type next_s; // next state

    // decoded control fields
    logic en, mst, clock_idle_level, clock_sample_edge, lsb;
    assign en   = s.ctrl[BIT_ENABLE];
    assign mst  = s.ctrl[BIT_MASTER];
    assign clock_idle_level = s.ctrl[BIT_CLOCK_IDLE_LEVEL];
    assign clock_sample_edge = s.ctrl[BIT_CLOCK_SAMPLE_EDGE];
    assign lsb  = s.ctrl[BIT_LSB];

    // next state logic
    always_comb begin
        logic       head;     // outgoing bit of the shift register
        logic       wr_data;  // write to data register
        logic       busy;     // any byte in flight
        logic       leading;  // slave edge leaves idle level
        logic [6:0] half;     // master half period
        head    = lsb ? s.shift[0] : s.shift[7];
        wr_data = wr_in && (addr_in == ADDR_DATA);
        busy    = s.m_busy || (s.bitcnt != CNT_ZERO);
        leading = 1'b0;
        half    = smsp_half_period(s.dbl,
                      {s.ctrl[BIT_RATE_HI], s.ctrl[BIT_RATE_LO]});
        next_s  = s;

        // two flop synchronisers; only stage two and later are used
        next_s.ss_s1  = ss_in;
        next_s.ss_s2  = s.ss_s1;
        next_s.sck_s1 = sck_in;
        next_s.sck_s2 = s.sck_s1;
        next_s.sck_s3 = s.sck_s2;

        // flag clearing by status read then data access
        if (rd_in && addr_in == ADDR_STATUS) begin
            next_s.arm_tcf  = s.tcf || s.write_collision_flag;
            next_s.arm_write_collision_flag = s.write_collision_flag;
        end
        if ((rd_in || wr_in) && addr_in == ADDR_DATA) begin
            if (s.arm_tcf) begin
                next_s.tcf = 1'b0;
            end
            if (s.arm_write_collision_flag) begin
                next_s.write_collision_flag = 1'b0;
            end
            next_s.arm_tcf  = 1'b0;
            next_s.arm_write_collision_flag = 1'b0;
        end
        // taking the interrupt vector clears the complete flag
        if (irq_ack_in) begin
            next_s.tcf = 1'b0;
        end

        // register writes
        if (wr_in && addr_in == ADDR_CONTROL) begin
            next_s.ctrl = wdata_in;
        end
        if (wr_in && addr_in == ADDR_STATUS) begin
            next_s.dbl = wdata_in[BIT_DOUBLE];
        end
        if (wr_data) begin
            if (busy) begin
                // single tx buffer: a busy write is refused
                next_s.write_collision_flag = 1'b1;
            end else begin
                next_s.shift  = wdata_in;
                next_s.tx_bit = lsb ? wdata_in[0] : wdata_in[7];
                if (en && mst) begin
                    next_s.m_busy   = 1'b1;
                    next_s.edge_cnt = CNT_ZERO;
                    next_s.div_cnt  = DIV_ZERO;
                end
            end
        end

        // master engine
        if (en && mst && s.m_busy) begin
            if (s.div_cnt == half - DIV_ONE) begin
                next_s.div_cnt = DIV_ZERO;
                next_s.sck_lvl = ~s.sck_lvl;
                if (s.edge_cnt[0] == clock_sample_edge) begin
                    // sample edge; even index is a leading edge
                    next_s.shift = smsp_shift_in(s.shift, miso_in,
                                                 lsb);
                end else begin
                    next_s.tx_bit = head;
                end
                next_s.edge_cnt = s.edge_cnt + CNT_ONE;
                if (s.edge_cnt == LAST_EDGE) begin
                    // eight bits out, clock generator stops
                    next_s.m_busy = 1'b0;
                    next_s.rxbuf  = next_s.shift;
                    next_s.tcf    = 1'b1;
                end
            end else begin
                next_s.div_cnt = s.div_cnt + DIV_ONE;
            end
        end else if (!s.m_busy) begin
            next_s.sck_lvl = clock_idle_level;
        end

        // low select input while master: another master takes over
        if (en && mst && !ss_dir_in && !s.ss_s2) begin
            next_s.ctrl[BIT_MASTER] = 1'b0;
            next_s.tcf      = 1'b1;
            next_s.m_busy   = 1'b0;
            next_s.edge_cnt = CNT_ZERO;
            next_s.sck_lvl  = clock_idle_level;
        end

        // slave engine; rate bits play no part here
        if (en && !mst) begin
            if (s.ss_s2) begin
                // deselected: reset the sample counter, present first bit
                next_s.bitcnt = CNT_ZERO;
                if (!wr_data) begin
                    next_s.tx_bit = head;
                end
            end else if (s.sck_s2 != s.sck_s3) begin
                leading = (s.sck_s2 != clock_idle_level);
                if (leading != clock_sample_edge) begin
                    // mosi is read late by the sync delay; external
                    // sck limits keep it stable across that delay
                    next_s.shift  = smsp_shift_in(s.shift, mosi_in,
                                        lsb);
                    next_s.bitcnt = s.bitcnt + CNT_ONE;
                    if (s.bitcnt == LAST_SAMPLE) begin
                        next_s.bitcnt = CNT_ZERO;
                        next_s.rxbuf  = next_s.shift;
                        next_s.tcf    = 1'b1;
                    end
                end else begin
                    next_s.tx_bit = head;
                end
            end
        end

        // disabled port performs no transfer
        if (!en) begin
            next_s.m_busy = 1'b0;
            next_s.bitcnt = CNT_ZERO;
        end

        // read answer, one cycle after the strobe
        next_s.rdata = BYTE_ZERO;
        if (rd_in) begin
            unique case (addr_in)
                ADDR_CONTROL: next_s.rdata = s.ctrl;
                ADDR_STATUS:  next_s.rdata = {s.tcf, s.write_collision_flag, 5'h00,
                                              s.dbl};
                ADDR_DATA:    next_s.rdata = s.rxbuf;
                default:      next_s.rdata = BYTE_ZERO;
            endcase
        end

        // interrupt request
        next_s.irq = next_s.ctrl[BIT_IRQ_EN] && next_s.tcf
                     && gie_in;

        // pin drivers
        next_s.sck_o   = next_s.sck_lvl;
        next_s.mosi_o  = next_s.tx_bit;
        next_s.miso_o  = next_s.tx_bit;
        next_s.sck_oe  = en && next_s.ctrl[BIT_MASTER] && sck_dir_in;
        next_s.mosi_oe = en && next_s.ctrl[BIT_MASTER]
                         && mosi_dir_in;
        next_s.miso_oe = en && !next_s.ctrl[BIT_MASTER] && !s.ss_s2
                         && miso_dir_in;
        next_s.ss_o    = ss_value_in;
        next_s.ss_oe   = ss_dir_in
                         && !(en && !next_s.ctrl[BIT_MASTER]);
    end

    // state register
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s       <= '0;
            s.ctrl  <= CONTROL_RESET;
            s.ss_s1 <= 1'b1;
            s.ss_s2 <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state register
    assign rdata_out   = s.rdata;
    assign irq_out     = s.irq;
    assign sck_out     = s.sck_o;
    assign sck_oe_out  = s.sck_oe;
    assign mosi_out    = s.mosi_o;
    assign mosi_oe_out = s.mosi_oe;
    assign miso_out    = s.miso_o;
    assign miso_oe_out = s.miso_oe;
    assign ss_out      = s.ss_o;
    assign ss_oe_out   = s.ss_oe;

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    a_rsv_read_zero: assert property (
        rd_in && addr_in == ADDR_STATUS |=> rdata_out[5:1] == 5'h00)
        else $error("reserved status bits not zero");
    a_mode_fault: assert property (
        en && mst && !ss_dir_in && !s.ss_s2 |=> !mst && s.tcf)
        else $error("select low did not drop master mode");
    a_fault_pins: assert property (
        en && mst && !ss_dir_in && !s.ss_s2 |=> ##1 !sck_oe_out
            && !mosi_oe_out)
        else $error("master pins still driven after fault");
    a_slave_ss_input: assert property (
        en && !mst ##1 en && !mst |-> !ss_oe_out)
        else $error("select pin driven in slave mode");
    a_slave_quiet: assert property (
        en && !mst && s.ss_s2 |=> s.bitcnt == CNT_ZERO && !miso_oe_out)
        else $error("deselected slave still active");
    a_disabled_idle: assert property (
        !en |=> !s.m_busy && s.bitcnt == CNT_ZERO)
        else $error("transfer while disabled");
    a_write_starts: assert property (
        wr_in && addr_in == ADDR_DATA && en && mst && !s.m_busy
            && s.bitcnt == CNT_ZERO && ss_dir_in |=> s.m_busy)
        else $error("data write did not start master transfer");
    a_write_collision_flag_set: assert property (
        wr_in && addr_in == ADDR_DATA && s.m_busy |=> s.write_collision_flag)
        else $error("collision not flagged");
    a_irq_gate: assert property (
        irq_out |-> $past(gie_in) && s.ctrl[BIT_IRQ_EN] && s.tcf)
        else $error("interrupt without enable and flag");
    a_sck_idle: assert property (
        en && mst && !s.m_busy ##1 !s.m_busy |=> sck_out == $past(clock_idle_level))
        else $error("sck not at idle level");
    a_master_done: assert property (
        $fell(s.m_busy) && mst |-> s.tcf && s.edge_cnt == CNT_ZERO)
        else $error("master stopped without completion");

    c_master_byte: cover property ($fell(s.m_busy) && mst);
    c_slave_byte: cover property (
        !mst && $rose(s.tcf) && s.bitcnt == CNT_ZERO);
    c_mode_fault: cover property ($fell(s.ctrl[BIT_MASTER]) && s.tcf);
    c_collision: cover property ($rose(s.write_collision_flag));
endmodule
`default_nettype wire

//--- smsp_pkg.sv
// constants, register map and helpers for the serial master/slave port
package smsp_pkg;
    // register word indices on the processor port
    localparam logic [1:0] ADDR_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_STATUS  = 2'h1;
    localparam logic [1:0] ADDR_DATA    = 2'h2;
    // control bit positions
    localparam int BIT_IRQ_EN   = 7;
    localparam int BIT_ENABLE   = 6;
    localparam int BIT_LSB      = 5;
    localparam int BIT_MASTER   = 4;
    localparam int BIT_CLOCK_IDLE_LEVEL     = 3;
    localparam int BIT_CLOCK_SAMPLE_EDGE     = 2;
    localparam int BIT_RATE_HI  = 1;
    localparam int BIT_RATE_LO  = 0;
    // status bit positions
    localparam int BIT_TCF      = 7;
    localparam int BIT_WRITE_COLLISION_FLAG     = 6;
    localparam int BIT_DOUBLE   = 0;
    // reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO     = 8'h00;
    // index of the last sample and of the last sck edge in a byte
    localparam logic [3:0] LAST_SAMPLE   = 4'h7;
    localparam logic [3:0] LAST_EDGE     = 4'hF;
    localparam logic [3:0] CNT_ZERO      = 4'h0;
    localparam logic [3:0] CNT_ONE       = 4'h1;
    localparam logic [6:0] DIV_ZERO      = 7'h00;
    localparam logic [6:0] DIV_ONE       = 7'h01;

    // half of the sck period in system clocks, per rate code
    function automatic logic [6:0] smsp_half_period(
        input logic       dbl,
        input logic [1:0] rate);
        logic [6:0] h;
        h = 7'h02;
        unique case ({dbl, rate})
            3'b000: h = 7'h02; // divide by 4
            3'b001: h = 7'h08; // divide by 16
            3'b010: h = 7'h20; // divide by 64
            3'b011: h = 7'h40; // divide by 128
            3'b100: h = 7'h01; // divide by 2
            3'b101: h = 7'h04; // divide by 8
            3'b110: h = 7'h10; // divide by 32
            3'b111: h = 7'h20; // divide by 64
        endcase
        return h;
    endfunction

    // shift one received bit in at the end opposite the outgoing one
    function automatic logic [7:0] smsp_shift_in(
        input logic [7:0] sh,
        input logic       b,
        input logic       lsb_first);
        return lsb_first ? {b, sh[7:1]} : {sh[6:0], b};
    endfunction
endpackage

//--- smsp_peer.sv
// behavioural serial slave that faces the port when it runs as master
`timescale 1ns/10ps
`default_nettype none
module smsp_peer (
    input  wire logic       clk_in,
    input  wire logic       ss_n_in,
    input  wire logic       sck_in,
    input  wire logic       mosi_in,
    input  wire logic       clock_idle_level_in,
    input  wire logic       clock_sample_edge_in,
    input  wire logic       lsb_in,
    input  wire logic [7:0] tx_in,
    output logic            miso_out,
    output logic [7:0]      rx_out
);
    int   idx;            // index of the bit now presented
    logic started = 1'b0; // first setup edge seen, phase 1 only
    logic tog = 1'b0;     // pattern shown while not selected
    logic lead;           // this edge leaves the idle level
    // deselected line flips every cycle so no stale bit can look valid
    always @(posedge clk_in) tog <= ~tog;
    assign miso_out = ss_n_in ? tog : tx_in[lsb_in ? idx : 7 - idx];
    // selection restarts the byte
    always @(negedge ss_n_in) begin
        idx = 0;
        started = 1'b0;
    end
    // sample and setup on opposite edges, chosen by phase
    always @(sck_in) begin
        lead = (sck_in != clock_idle_level_in);
        if (!ss_n_in && lead != clock_sample_edge_in) begin
            rx_out = lsb_in ? {mosi_in, rx_out[7:1]}
                            : {rx_out[6:0], mosi_in};
        end else if (!ss_n_in) begin
            // phase 1: the first leading edge only launches bit 0
            if ((!clock_sample_edge_in || started) && idx < 7) idx = idx + 1;
            started = 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- smsp_port_bench.sv
// self-checking bench for the serial master/slave port
`timescale 1ns/10ps
`default_nettype none
module smsp_port_bench;
    import smsp_pkg::*;
    logic        clk_in = 1'b0, resetn_in = 1'b0; // clock, reset
    logic [1:0]  addr = 2'h0;                    // register index
    logic [7:0]  wdata = 8'h00;                  // bus write data
    logic        wr = 1'b0, rd = 1'b0, ack = 1'b0; // strobes
    logic        ss_dir = 1'b1, ss_val = 1'b1, miso_dir = 1'b0;
    logic        bsck = 1'b0, bmosi = 1'b0, bss = 1'b1; // bench pins
    logic        clock_idle_level = 1'b0, clock_sample_edge = 1'b0, lsb = 1'b0, sck_q = 1'b0;
    logic        meas = 1'b0;                    // half period watch
    logic [7:0]  rdata, peer_tx, peer_rx, d, s;
    logic        irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
    logic        ss_o, ss_oe, peer_miso;
    int          bad_count = 0, comparisons = 0, edges = 0, run = 0;
    int          half;
    int          halfs[8] = '{2, 8, 32, 64, 1, 4, 16, 32};
    logic [31:0] seed = 32'h0000E3BE;            // 58302
    logic [7:0]  exp_q[$];                       // bytes due on read
    wire sck_w  = sck_oe ? sck_o : bsck;
    wire mosi_w = mosi_oe ? mosi_o : bmosi;
    wire miso_w = miso_oe ? miso_o : peer_miso;
    wire ss_w   = ss_oe ? ss_o : bss;
    wire peer_ss = ~ss_oe | ss_o;  // peer answers only to our select
    always #2 clk_in = ~clk_in;
    smsp_port dut (.clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .gie_in(1'b1), .irq_ack_in(ack), .irq_out(irq),
        .sck_dir_in(1'b1), .mosi_dir_in(1'b1), .miso_dir_in(miso_dir),
        .ss_dir_in(ss_dir), .ss_value_in(ss_val), .sck_in(sck_w),
        .sck_out(sck_o), .sck_oe_out(sck_oe), .mosi_in(mosi_w),
        .mosi_out(mosi_o), .mosi_oe_out(mosi_oe), .miso_in(miso_w),
        .miso_out(miso_o), .miso_oe_out(miso_oe), .ss_in(ss_w),
        .ss_out(ss_o), .ss_oe_out(ss_oe));
    smsp_peer peer (.clk_in(clk_in), .ss_n_in(peer_ss), .sck_in(sck_w),
        .mosi_in(mosi_w), .clock_idle_level_in(clock_idle_level), .clock_sample_edge_in(clock_sample_edge), .lsb_in(lsb),
        .tx_in(peer_tx), .miso_out(peer_miso), .rx_out(peer_rx));
    // xorshift source for data bytes
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic results();
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk_in);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [1:0] a, input logic [7:0] e);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        @(negedge clk_in);
        chk(rdata, e);
    endtask
    task automatic pulse_ack();
        @(posedge clk_in);
        ack <= 1'b1;
        @(posedge clk_in);
        ack <= 1'b0;
    endtask
    // bounded wait for the interrupt line
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 6000) begin
            @(posedge clk_in);
            n++;
        end
        if (n >= 6000) begin
            bad_count++;
            results();
        end
    endtask
    // bench acting as external master, mode 0, sck = clk/12
    // six clocks high and six low keep the slave sampling safe
    task automatic xfer(input logic [7:0] m, input int nb);
        bss <= 1'b0;
        step(8);
        chk({ss_oe, miso_oe}, {1'b0, miso_dir});
        for (int k = 0; k < nb; k++) begin
            bmosi <= m[7 - k];
            step(6);
            s = {s[6:0], miso_w};
            bsck <= 1'b1;
            step(6);
            bsck <= 1'b0;
        end
        step(6);
        bss <= 1'b1;
        step(6);
    endtask
    // half period and edge count of the generated serial clock
    always @(posedge clk_in) begin
        sck_q <= sck_o;
        if (sck_o !== sck_q) begin
            if (meas && edges > 0) chk(8'(run), 8'(half));
            edges <= edges + 1;
            run <= 1;
        end else begin
            run <= run + 1;
        end
    end
    initial begin
        step(4);
        resetn_in <= 1'b1;
        for (int a = 0; a < 4; a++) rd_chk(2'(a), 8'h00);
        wr_reg(2'h3, 8'hFF);
        wr_reg(ADDR_STATUS, 8'hFF);
        rd_chk(ADDR_STATUS, 8'h01);
        // master: every rate code, every clock mode, both orders
        for (int i = 0; i < 8; i++) begin
            {clock_idle_level, clock_sample_edge} = 2'(i);
            lsb = i[0] ^ i[2];
            half = halfs[i];
            peer_tx = rnd();
            d = rnd();
            wr_reg(ADDR_STATUS, {7'h00, i[2]});
            wr_reg(ADDR_CONTROL, {2'b11, lsb, 1'b1, clock_idle_level, clock_sample_edge, i[1:0]});
            // let sck settle to its new idle level before selecting
            step(1);
            ss_val <= 1'b0;
            step(3);
            chk({ss_o, sck_o}, {1'b0, clock_idle_level});
            edges = 0;
            meas = 1'b1;
            wr_reg(ADDR_DATA, d);
            exp_q.push_back(peer_tx);
            if (i == 0) wr_reg(ADDR_DATA, ~d);
            wait_irq();
            // one more edge so the last toggle is counted and timed
            step(1);
            meas = 1'b0;
            chk(8'(edges), 8'h10);
            chk(peer_rx, d);
            ss_val <= 1'b1;
            if (i[0]) pulse_ack();
            else rd_chk(ADDR_STATUS, {1'b1, i == 0, 5'h00, i[2]});
            rd_chk(ADDR_DATA, exp_q.pop_front());
            rd_chk(ADDR_STATUS, {7'h00, i[2]});
            chk({7'h00, irq}, 8'h00);
        end
        // port disabled: a data write must not start anything
        wr_reg(ADDR_CONTROL, 8'h10);
        wr_reg(ADDR_DATA, 8'hA5);
        // sck returning to idle after the mode change is not a transfer
        step(2);
        edges = 0;
        step(100);
        chk(8'(edges), 8'h00);
        rd_chk(ADDR_STATUS, 8'h01);
        // low select input while master drops the port to slave
        ss_dir <= 1'b0;
        wr_reg(ADDR_CONTROL, 8'h50);
        bss <= 1'b0;
        step(6);
        rd_chk(ADDR_CONTROL, 8'h40);
        rd_chk(ADDR_STATUS, 8'h81);
        chk({6'h00, sck_oe, mosi_oe}, 8'h00);
        pulse_ack();
        bss <= 1'b1;
        // the synchronised select must be high again before re-arming
        step(3);
        wr_reg(ADDR_CONTROL, 8'h50);
        rd_chk(ADDR_CONTROL, 8'h50);
        // slave: rate bits set but ignored, select pin forced to input
        ss_dir <= 1'b1;
        miso_dir <= 1'b1;
        wr_reg(ADDR_CONTROL, 8'h43);
        d = rnd();
        wr_reg(ADDR_DATA, d);
        exp_q.push_back(rnd());
        xfer(exp_q[0], 8);
        chk(s, d);
        rd_chk(ADDR_STATUS, 8'h81);
        rd_chk(ADDR_DATA, exp_q.pop_front());
        // a byte cut short by deselection is dropped
        xfer(8'hFF, 3);
        d = rnd();
        wr_reg(ADDR_DATA, d);
        exp_q.push_back(rnd());
        xfer(exp_q[0], 8);
        chk(s, d);
        chk({7'h00, miso_oe}, 8'h00);
        rd_chk(ADDR_STATUS, 8'h81);
        rd_chk(ADDR_DATA, exp_q.pop_front());
        results();
    end
endmodule
`default_nettype wire
